// ==== rtl/rvt_top.v ====
/*
 Raw VBI capture and encoder timing packet output with Wishbone registers.
 Assumes line timing, samples and pixel enable come from logic on clk,
 and that horizontal blanking holds at least 19 pixel enables after EAV.
*/
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "rvt_map.vh"
module rvt_top (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Video timing
  input  wire        pixEn,
  input  wire [9:0]  lineNum,
  input  wire        lineBlank,
  input  wire [10:0] sampleCount,
  input  wire        eavDone,
  input  wire        savStart,
  input  wire        vPositive,
  // Video data
  input  wire [7:0]  videoSample,
  input  wire [7:0]  videoUpper,
  input  wire        slicedValid,
  input  wire [7:0]  slicedByte,
  // Pixel outputs
  output reg  [15:0] pixelOut,
  output reg         rawActive,
  output reg         ancActive
);
  // Reset release
  reg rstMeta_reg;
  reg rstSync_reg;
  wire rstSync_n;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstSync_n = rstSync_reg;

  // Byte-lane merge for writes
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          laneMerge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Registers
  reg [4:0]  ctrl_reg;
  reg [10:0] start_reg;
  reg [10:0] stop_reg;
  reg [18:0] mask_reg;
  reg [7:0]  blank_reg;
  reg [31:0] fsc_reg;
  reg        pktBusy_reg;
  wire       wbReq;
  wire       wbWrite;
  wire [31:0] mergedCtrl;
  wire [31:0] mergedStart;
  wire [31:0] mergedStop;
  wire [31:0] mergedMask;
  wire [31:0] mergedBlank;
  wire [31:0] mergedFsc;
  reg  [31:0] readData;

  assign wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbReq && wb_we_i;
  assign mergedCtrl  = laneMerge({27'h0, ctrl_reg}, wb_dat_i, wb_sel_i);
  assign mergedStart = laneMerge({21'h0, start_reg}, wb_dat_i, wb_sel_i);
  assign mergedStop  = laneMerge({21'h0, stop_reg}, wb_dat_i, wb_sel_i);
  assign mergedMask  = laneMerge({13'h0, mask_reg}, wb_dat_i, wb_sel_i);
  assign mergedBlank = laneMerge({24'h0, blank_reg}, wb_dat_i, wb_sel_i);
  assign mergedFsc   = laneMerge(fsc_reg, wb_dat_i, wb_sel_i);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= `RVT_RST_CTRL;
      start_reg <= `RVT_RST_START;
      stop_reg  <= `RVT_RST_STOP;
      mask_reg  <= `RVT_RST_MASK;
      blank_reg <= `RVT_RST_BLANK;
      fsc_reg   <= `RVT_RST_FSC;
    end else if (!rstSync_n) begin
      ctrl_reg  <= `RVT_RST_CTRL;
      start_reg <= `RVT_RST_START;
      stop_reg  <= `RVT_RST_STOP;
      mask_reg  <= `RVT_RST_MASK;
      blank_reg <= `RVT_RST_BLANK;
      fsc_reg   <= `RVT_RST_FSC;
    end else if (wbWrite) begin
      case (wb_adr_i)
        `RVT_OFS_CTRL:  ctrl_reg  <= mergedCtrl[4:0];
        `RVT_OFS_START: start_reg <= mergedStart[10:0];
        `RVT_OFS_STOP:  stop_reg  <= mergedStop[10:0];
        `RVT_OFS_MASK:  mask_reg  <= mergedMask[18:0];
        `RVT_OFS_BLANK: blank_reg <= mergedBlank[7:0];
        `RVT_OFS_FSC:   fsc_reg   <= mergedFsc;
        default: ;
      endcase
    end
  end

  always @* begin
    case (wb_adr_i)
      `RVT_OFS_CTRL:   readData = {27'h0, ctrl_reg};
      `RVT_OFS_START:  readData = {21'h0, start_reg};
      `RVT_OFS_STOP:   readData = {21'h0, stop_reg};
      `RVT_OFS_MASK:   readData = {13'h0, mask_reg};
      `RVT_OFS_BLANK:  readData = {24'h0, blank_reg};
      `RVT_OFS_FSC:    readData = fsc_reg;
      `RVT_OFS_STATUS: readData = {6'h0, lineNum, 14'h0,
                                   pktBusy_reg, rawActive};
      default:         readData = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (!rstSync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        wb_dat_o <= readData;
      end
    end
  end

  // Raw capture path
  wire [1:0] std;
  wire       lineOk;
  wire       rawNow;
  wire [7:0] rawValue;

  assign std = ctrl_reg[`RVT_CTRL_STD_HI:`RVT_CTRL_STD_LO];

  rvt_line_gate uGate (
    .std       (std),
    .everyLine (ctrl_reg[`RVT_CTRL_EVERY]),
    .lineMask  (mask_reg),
    .lineNum   (lineNum),
    .lineBlank (lineBlank),
    .eligible  (lineOk)
  );

  assign rawNow = ctrl_reg[`RVT_CTRL_RAW_EN] && lineOk &&
                  sampleCount >= start_reg &&
                  sampleCount <= stop_reg;
  // Below blanking clips to zero
  assign rawValue = (videoSample > blank_reg) ?
                    videoSample - blank_reg : 8'h00;

  // Timing packet sequencer
  reg [4:0]  wordIdx_reg;
  reg [6:0]  sum_reg;
  reg [31:0] fscSh_reg;
  reg        psw_reg;
  reg        isPre;
  reg [7:0]  preByte;
  reg        isCrc;
  reg [5:0]  data6;
  wire [7:0] ancWord;
  wire       inPayload;
  wire       inFsc;

  assign inPayload = wordIdx_reg >= `RVT_W_DID && wordIdx_reg < `RVT_W_CRC;
  assign inFsc = wordIdx_reg >= `RVT_W_FSC0 && wordIdx_reg < `RVT_W_CRC;

  always @* begin
    isPre   = 1'b0;
    preByte = `RVT_PRE0;
    isCrc   = 1'b0;
    data6   = 6'h00;
    if (wordIdx_reg < `RVT_W_DID) begin
      isPre   = 1'b1;
      preByte = (wordIdx_reg == 5'h00) ? `RVT_PRE0 : `RVT_PRE1;
    end else if (wordIdx_reg == `RVT_W_DID) begin
      data6 = `RVT_DID;
    end else if (wordIdx_reg == `RVT_W_DBN) begin
      data6 = `RVT_DBN;
    end else if (wordIdx_reg == `RVT_W_DCNT) begin
      data6 = `RVT_DCNT;
    end else if (wordIdx_reg == `RVT_W_FSC0) begin
      data6 = {psw_reg, 1'b0, fscSh_reg[31:28]};
    end else if (inFsc) begin
      data6 = {2'b00, fscSh_reg[31:28]};
    end else if (wordIdx_reg == `RVT_W_CRC) begin
      isCrc = 1'b1;
    end
  end

  rvt_anc_coder uCoder (
    .isPre   (isPre),
    .preByte (preByte),
    .isCrc   (isCrc),
    .data6   (data6),
    .sum     (sum_reg),
    .word    (ancWord)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pktBusy_reg <= 1'b0;
      wordIdx_reg <= 5'h00;
      sum_reg     <= 7'h00;
      fscSh_reg   <= 32'h00000000;
      psw_reg     <= 1'b0;
    end else if (!rstSync_n) begin
      pktBusy_reg <= 1'b0;
      wordIdx_reg <= 5'h00;
      sum_reg     <= 7'h00;
      fscSh_reg   <= 32'h00000000;
      psw_reg     <= 1'b0;
    end else if (savStart) begin
      pktBusy_reg <= 1'b0;
    end else if (!pktBusy_reg) begin
      if (eavDone && ctrl_reg[`RVT_CTRL_PKT_EN]) begin
        pktBusy_reg <= 1'b1;
        wordIdx_reg <= 5'h00;
        sum_reg     <= 7'h00;
        fscSh_reg   <= fsc_reg;
        psw_reg     <= (std == `RVT_STD_NTSC) ? 1'b0 : vPositive;
      end
    end else if (pixEn) begin
      if (inPayload) begin
        sum_reg <= sum_reg + ancWord[6:0];
      end
      if (inFsc) begin
        fscSh_reg <= fscSh_reg << `RVT_NIB;
      end
      if (wordIdx_reg == `RVT_W_CRC) begin
        pktBusy_reg <= 1'b0;
      end else begin
        wordIdx_reg <= wordIdx_reg + 5'h01;
      end
    end
  end

  // Output lanes: packet, sliced data or videoUpper high; raw samples or videoSample low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixelOut  <= 16'h0000;
      rawActive <= 1'b0;
      ancActive <= 1'b0;
    end else if (!rstSync_n) begin
      pixelOut  <= 16'h0000;
      rawActive <= 1'b0;
      ancActive <= 1'b0;
    end else if (pixEn) begin
      ancActive <= pktBusy_reg && !savStart;
      if (pktBusy_reg && !savStart) begin
        pixelOut[15:8] <= ancWord;
      end else if (slicedValid) begin
        pixelOut[15:8] <= slicedByte;
      end else begin
        pixelOut[15:8] <= videoUpper;
      end
      rawActive <= rawNow;
      pixelOut[7:0] <= rawNow ? rawValue : videoSample;
    end
  end
endmodule

// ==== pkg/rvt_map.vh ====
/*
 Constants for the raw VBI capture and encoder timing packet block.
 Assumes inclusion by bare name from files under rtl/.
*/
// How it works
// - Enabled raw lines put pixel-rate samples of their active period on outputs.
// - Raw lines follow the line mask; every-line mode skips equalization lines.
// - Raw capture per line lies between programmable start and stop counts.
// - Blanking level is subtracted from each raw sample before output.
// - Sliced ancillary data and raw samples coexist on one line.
// - NTSC first eligible lines 10 and 272; 1-9 and 264-271 blanked.
// - 625-line PAL first eligible 6 and 318; 623-5, 311-317 blanked.
// - PAL M first eligible 7 and 269; 523-6, 261-268 blanked.
// - Timing packet on upper lanes: 00 FF FF, ID, block one, count three.
// - Subcarrier increment sent as eight nibbles MSB first, sign flag first.
// - Second subcarrier word has zero field flags; line-lock words zero.
// - Bit above six data bits gives even parity over the seven.
// - Checksum is carry-free sum of low seven bits, ID to last payload.
// - One packet per line when enabled, finished before SAV.
// - Sign flag zero in NTSC; in PAL one when V positive.
`ifndef RVT_MAP_VH
`define RVT_MAP_VH

// Register byte offsets
`define RVT_OFS_CTRL     8'h00
`define RVT_OFS_START    8'h04
`define RVT_OFS_STOP     8'h08
`define RVT_OFS_MASK     8'h0c
`define RVT_OFS_BLANK    8'h10
`define RVT_OFS_FSC      8'h14
`define RVT_OFS_STATUS   8'h18

// Control fields
`define RVT_CTRL_RAW_EN  0
`define RVT_CTRL_EVERY   1
`define RVT_CTRL_PKT_EN  2
`define RVT_CTRL_STD_LO  3
`define RVT_CTRL_STD_HI  4
`define RVT_CTRL_W       5

// Reset values
`define RVT_RST_CTRL     5'h00
`define RVT_RST_START    11'h07a
`define RVT_RST_STOP     11'h34a
`define RVT_RST_MASK     19'h71ffe
`define RVT_RST_BLANK    8'h10
`define RVT_RST_FSC      32'h00000000

// Video standards
`define RVT_STD_NTSC     2'h0
`define RVT_STD_PAL      2'h1
`define RVT_STD_PALM     2'h2

// Line numbers per standard
`define RVT_NTSC_F1      10'h00a
`define RVT_NTSC_F2BLK   10'h108
`define RVT_NTSC_F2      10'h110
`define RVT_PAL_F1       10'h006
`define RVT_PAL_F2BLK    10'h137
`define RVT_PAL_F2       10'h13e
`define RVT_PAL_WRAP     10'h26f
`define RVT_PALM_F1      10'h007
`define RVT_PALM_F2BLK   10'h105
`define RVT_PALM_F2      10'h10d
`define RVT_PALM_WRAP    10'h20b
`define RVT_MASK_BITS    10'h013

// Packet words
`define RVT_PRE0         8'h00
`define RVT_PRE1         8'hff
`define RVT_DID          6'h35
`define RVT_DBN          6'h01
`define RVT_DCNT         6'h03
`define RVT_W_PRE2       5'h02
`define RVT_W_DID        5'h03
`define RVT_W_DBN        5'h04
`define RVT_W_DCNT       5'h05
`define RVT_W_FSC0       5'h0a
`define RVT_W_FSC1       5'h0b
`define RVT_W_CRC        5'h12
`define RVT_NIB          6'h04

`endif

// ==== rtl/rvt_line_gate.v ====
/*
 Decides whether the current scan line may carry raw VBI samples.
 Assumes a 1-based frame line number and a blanked-line flag from timing.
*/
`timescale 1ns/1ps
`include "rvt_map.vh"
module rvt_line_gate (
  // Setup
  input  wire [1:0]  std,
  input  wire        everyLine,
  input  wire [18:0] lineMask,
  // Line timing
  input  wire [9:0]  lineNum,
  input  wire        lineBlank,
  // Result
  output reg         eligible
);
  reg [9:0] f1First;
  reg [9:0] f2Blank;
  reg [9:0] f2First;
  reg [9:0] wrapLine;
  reg       wrapEn;
  reg       forced;
  reg [9:0] idx;
  reg       inMask;

  always @* begin
    f1First  = `RVT_NTSC_F1;
    f2Blank  = `RVT_NTSC_F2BLK;
    f2First  = `RVT_NTSC_F2;
    wrapLine = `RVT_PAL_WRAP;
    wrapEn   = 1'b0;
    case (std)
      `RVT_STD_NTSC: begin
        f1First = `RVT_NTSC_F1;
      end
      `RVT_STD_PALM: begin
        f1First  = `RVT_PALM_F1;
        f2Blank  = `RVT_PALM_F2BLK;
        f2First  = `RVT_PALM_F2;
        wrapLine = `RVT_PALM_WRAP;
        wrapEn   = 1'b1;
      end
      default: begin
        f1First  = `RVT_PAL_F1;
        f2Blank  = `RVT_PAL_F2BLK;
        f2First  = `RVT_PAL_F2;
        wrapLine = `RVT_PAL_WRAP;
        wrapEn   = 1'b1;
      end
    endcase
    // Equalization and serration lines never carry data
    forced = (lineNum < f1First) ||
             (lineNum >= f2Blank && lineNum < f2First) ||
             (wrapEn && lineNum >= wrapLine);
    idx = (lineNum >= f2First) ? lineNum - f2First : lineNum - f1First;
    inMask = (idx < `RVT_MASK_BITS) && lineMask[idx[4:0]];
    eligible = !forced && (everyLine || (lineBlank && inMask));
  end
endmodule

// ==== rtl/rvt_anc_coder.v ====
/*
 Codes one ancillary byte: preamble passthrough, parity word or checksum.
 Assumes the caller accumulates the checksum over the coded words.
*/
`timescale 1ns/1ps
module rvt_anc_coder (
  // Word selection
  input  wire       isPre,
  input  wire [7:0] preByte,
  input  wire       isCrc,
  input  wire [5:0] data6,
  input  wire [6:0] sum,
  // Coded byte
  output wire [7:0] word
);
  wire parity;

  assign parity = ^data6;
  assign word = isPre ? preByte :
                isCrc ? {~sum[6], sum} :
                {~parity, parity, data6};
endmodule

// ==== verif/rvt_top_chk_asserts.sv ====
/* Port assertions for rvt_top.
 Assumes a bind into rvt_top; standard and blank level shadowed from writes. */
`timescale 1ns/1ps
`include "rvt_map.vh"
module rvt_top_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Video
  input wire logic        pixEn,
  input wire logic [9:0]  lineNum,
  input wire logic [7:0]  videoSample,
  input wire logic [15:0] pixelOut,
  input wire logic        rawActive,
  input wire logic        ancActive
);
  logic       pixEnQ;
  logic [4:0] idx_reg;
  logic [1:0] std_reg;
  logic [7:0] blank_reg;
  logic [7:0] vsQ;
  logic [9:0] lnQ;
  wire        anc = pixEnQ && ancActive;
  wire        raw = pixEnQ && rawActive;
  wire  [7:0] b = pixelOut[15:8];
  wire  [7:0] rawExp = vsQ > blank_reg ? vsQ - blank_reg : 8'h00;
  wire        wr = wb_ack_o && wb_we_i;

  // Byte index of the packet on the upper lane
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixEnQ    <= 1'b0;
      idx_reg   <= 5'h00;
      std_reg   <= `RVT_STD_NTSC;
      blank_reg <= `RVT_RST_BLANK;
      vsQ       <= 8'h00;
      lnQ       <= 10'h000;
    end else begin
      pixEnQ <= pixEn;
      vsQ    <= videoSample;
      lnQ    <= lineNum;
      if (pixEnQ)
        idx_reg <= ancActive ? idx_reg + 5'h01 : 5'h00;
      if (wr && wb_adr_i == `RVT_OFS_CTRL)
        std_reg <= wb_dat_i[4:3];
      if (wr && wb_adr_i == `RVT_OFS_BLANK)
        blank_reg <= wb_dat_i[7:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |->
    ##1 wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_pre; anc && idx_reg < 5'h03 |->
    b == (idx_reg == 5'h00 ? 8'h00 : 8'hff); endproperty
  a_pre: assert property (p_pre) else $error("bad preamble");
  property p_did; anc && idx_reg == `RVT_W_DID |->
    b[5:0] == `RVT_DID; endproperty
  a_did: assert property (p_did) else $error("bad identifier");
  property p_par; anc && idx_reg > 5'h02 && idx_reg < `RVT_W_CRC |->
    !(^b[6:0]); endproperty
  a_par: assert property (p_par) else $error("bad parity");
  property p_inv; anc && idx_reg > 5'h02 |-> b[7] != b[6]; endproperty
  a_inv: assert property (p_inv) else $error("bad top bit");
  property p_zero; anc && idx_reg > 5'h05 && idx_reg < 5'h0a |->
    b[5:0] == 6'h00; endproperty
  a_zero: assert property (p_zero) else $error("line-lock not zero");
  property p_fld; anc && idx_reg == `RVT_W_FSC1 |->
    b[5:4] == 2'h0; endproperty
  a_fld: assert property (p_fld) else $error("field flags set");
  property p_sign; anc && idx_reg == `RVT_W_FSC0 &&
    std_reg == `RVT_STD_NTSC |-> !b[5]; endproperty
  a_sign: assert property (p_sign) else $error("sign set in NTSC");
  property p_len; $rose(ancActive) |-> ##[1:60] !ancActive; endproperty
  a_len: assert property (p_len) else $error("packet too long");
  property p_sub; raw |-> pixelOut[7:0] == rawExp; endproperty
  a_sub: assert property (p_sub) else $error("bad raw value");
  property p_blk; raw && std_reg == `RVT_STD_NTSC |->
    !(lnQ inside {[1:9], [264:271]}); endproperty
  a_blk: assert property (p_blk) else $error("raw on blanked line");
endmodule

bind rvt_top rvt_top_chk u_chk (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pixEn(pixEn), .lineNum(lineNum),
  .videoSample(videoSample), .pixelOut(pixelOut),
  .rawActive(rawActive), .ancActive(ancActive)
);

// ==== verif/rvt_enc_model.sv ====
/* Encoder side of the pixel bus: collects and checks timing packets.
 Assumes one upper-lane byte per pixEn while ancActive is high. */
`timescale 1ns/1ps
`include "rvt_map.vh"
module rvt_enc_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Pixel bus
  input  wire logic        pixEn,
  input  wire logic        ancActive,
  input  wire logic [15:0] pixelOut,
  // Decoded result
  output logic      [7:0]  goodCnt,
  output logic      [7:0]  badCnt,
  output logic      [31:0] fscSeen,
  output logic             signSeen
);
  logic       pixEnQ;
  logic [4:0] n;
  logic [7:0] w [0:18];

  // Identify, then parity and checksum
  function automatic logic pktGood();
    logic [6:0] s;
    logic       ok;
    s  = 7'h00;
    ok = n == 5'h13 && w[0] == 8'h00 && w[1] == 8'hff && w[2] == 8'hff;
    ok = ok && w[3][5:0] == `RVT_DID && w[4][5:0] == `RVT_DBN;
    ok = ok && w[5][5:0] == `RVT_DCNT;
    for (int i = 3; i < 19; i++) begin
      ok = ok && w[i][7] != w[i][6];
      ok = ok && (i == 18 || !(^w[i][6:0]));
      if (i < 18)
        s = s + w[i][6:0];
    end
    return ok && s == w[18][6:0];
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixEnQ   <= 1'b0;
      n        <= 5'h00;
      goodCnt  <= 8'h00;
      badCnt   <= 8'h00;
      fscSeen  <= 32'h0;
      signSeen <= 1'b0;
    end else begin
      pixEnQ <= pixEn;
      if (pixEnQ && ancActive && n < 5'h13) begin
        w[n] <= pixelOut[15:8];
        n    <= n + 5'h01;
      end else if (pixEnQ && !ancActive && n != 5'h00) begin
        if (pktGood()) begin
          goodCnt  <= goodCnt + 8'h01;
          fscSeen  <= {w[10][3:0], w[11][3:0], w[12][3:0], w[13][3:0],
                       w[14][3:0], w[15][3:0], w[16][3:0], w[17][3:0]};
          signSeen <= w[10][5];
        end else
          badCnt <= badCnt + 8'h01;
        n <= 5'h00;
      end
    end
  end
endmodule

// ==== verif/rvt_top_tb.sv ====
/* Self-checking bench for rvt_top.
 Assumes the encoder model on the pixel bus and the bound checker. */
`timescale 1ns/1ps
`include "rvt_map.vh"
module rvt_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, videoSample = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic        pixEn = 1'b0, lineBlank = 1'b0, eavDone = 1'b0;
  logic        savStart = 1'b0, vPositive = 1'b0, slicedValid = 1'b0;
  logic [9:0]  lineNum = 10'h000;
  logic [10:0] sampleCount = 11'h000;
  wire  [31:0] datO, fscSeen;
  wire  [15:0] pixelOut;
  wire  [7:0]  goodCnt, badCnt;
  wire         ack, rawActive, ancActive, signSeen;
  int          n_fail = 0;
  int          n_tests = 0;

  rvt_top dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(datO),
    .wb_ack_o(ack), .pixEn(pixEn), .lineNum(lineNum), .lineBlank(lineBlank),
    .sampleCount(sampleCount), .eavDone(eavDone), .savStart(savStart),
    .vPositive(vPositive), .videoSample(videoSample), .videoUpper(8'h33),
    .slicedValid(slicedValid), .slicedByte(8'h5a), .pixelOut(pixelOut),
    .rawActive(rawActive), .ancActive(ancActive)
  );
  rvt_enc_model partner (
    .clk(clk), .rst_n(rst_n), .pixEn(pixEn), .ancActive(ancActive),
    .pixelOut(pixelOut), .goodCnt(goodCnt), .badCnt(badCnt),
    .fscSeen(fscSeen), .signSeen(signSeen)
  );

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) pixEn <= ~pixEn;

  task automatic test_done;
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; ack is sampled as a flop would see it
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read", e, rdat);
  endtask

  task automatic raw(input logic [4:0] c, input logic [9:0] l, input logic bl,
                     input logic [10:0] s, input logic [7:0] v, input logic a);
    bus(1'b1, `RVT_OFS_CTRL, {27'h0, c});
    lineNum     <= l;
    lineBlank   <= bl;
    sampleCount <= s;
    videoSample <= v;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("rawActive", {31'h0, a}, {31'h0, rawActive});
    if (a) begin
      chk("rawData", {24'h0, v > 8'h10 ? v - 8'h10 : 8'h00},
          {24'h0, pixelOut[7:0]});
      chk("sliced", 32'h5a, {24'h0, pixelOut[15:8]});
    end
  endtask

  task automatic pulse(input logic sav);
    @(posedge clk);
    if (sav)
      savStart <= 1'b1;
    else
      eavDone <= 1'b1;
    @(posedge clk);
    savStart <= 1'b0;
    eavDone  <= 1'b0;
  endtask

  // Second start mid-packet must be ignored
  task automatic pkt(input logic [1:0] s, input logic v,
                     input logic [31:0] f);
    logic [7:0] g0;
    g0 = goodCnt;
    bus(1'b1, `RVT_OFS_FSC, f);
    bus(1'b1, `RVT_OFS_CTRL, {27'h0, s, 3'h4});
    vPositive <= v;
    pulse(1'b0);
    repeat (12) @(posedge clk);
    pulse(1'b0);
    repeat (100) @(posedge clk);
    chk("packets", {24'h0, g0 + 8'h01}, {24'h0, goodCnt});
    chk("increment", f, fscSeen);
    chk("sign", {31'h0, s != 2'h0 && v}, {31'h0, signSeen});
  endtask

  initial begin
    #100000;
    n_fail++;
    test_done;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`RVT_OFS_CTRL, 32'h0);
    rd(`RVT_OFS_START, 32'h7a);
    rd(`RVT_OFS_STOP, 32'h34a);
    rd(`RVT_OFS_MASK, 32'h71ffe);
    rd(8'h40, 32'h0);
    bus(1'b1, `RVT_OFS_FSC, 32'h12345678);
    rd(`RVT_OFS_FSC, 32'h12345678);
    slicedValid <= 1'b1;
    raw(5'h01, 10'h00b, 1'b1, 11'h0c8, 8'h50, 1'b1);
    rd(`RVT_OFS_STATUS, 32'h000b0001);
    raw(5'h00, 10'h00b, 1'b1, 11'h0c8, 8'h50, 1'b0);
    raw(5'h01, 10'h00a, 1'b1, 11'h0c8, 8'h50, 1'b0);
    raw(5'h01, 10'h00b, 1'b0, 11'h0c8, 8'h50, 1'b0);
    raw(5'h01, 10'h00b, 1'b1, 11'h079, 8'h50, 1'b0);
    raw(5'h01, 10'h00b, 1'b1, 11'h07a, 8'h08, 1'b1);
    raw(5'h01, 10'h00b, 1'b1, 11'h34b, 8'h50, 1'b0);
    raw(5'h01, 10'h111, 1'b1, 11'h0c8, 8'h60, 1'b1);
    raw(5'h03, 10'h064, 1'b0, 11'h0c8, 8'h50, 1'b1);
    raw(5'h03, 10'h009, 1'b1, 11'h0c8, 8'h50, 1'b0);
    raw(5'h03, 10'h10f, 1'b1, 11'h0c8, 8'h50, 1'b0);
    raw(5'h0b, 10'h006, 1'b1, 11'h0c8, 8'h50, 1'b1);
    raw(5'h0b, 10'h13d, 1'b1, 11'h0c8, 8'h50, 1'b0);
    raw(5'h13, 10'h007, 1'b1, 11'h0c8, 8'h50, 1'b1);
    raw(5'h13, 10'h10c, 1'b1, 11'h0c8, 8'h50, 1'b0);
    slicedValid <= 1'b0;
    for (int i = 0; i < 6; i++)
      pkt(i[1:0], !i[2],
          32'h9abcdef1 ^ {i[7:0], 24'h0});
    pulse(1'b0);
    repeat (10) @(posedge clk);
    pulse(1'b1);
    repeat (60) @(posedge clk);
    chk("aborted", 32'h1, {24'h0, badCnt});
    test_done;
  end
endmodule
